// *** rtl/adc_seq_regs.svh ***
// Constants for the stereo converter conversion sequencer: offsets, fields, resets, timing.
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STAT 8'h08
`define REG_IRQ_MASK 8'h0C
`define REG_RESULT 8'h10

`define CTRL_TWOS_BIT 0
`define STAT_READY_BIT 0
`define STAT_CONV_BIT 1
`define STAT_RIGHT_BIT 2
`define IRQ_W 3
`define IRQ_CONV_BIT 0
`define IRQ_CAL_BIT 1
`define IRQ_SAT_BIT 2
`define CTRL_RESET 1'h0
`define IRQ_MASK_RESET 3'h0

`define RES_W 16
`define TRIM_W 4
`define CAL_CNT_W 26
`define CAL_CYC_DEFAULT 34584480
`define TRK_FALL_CYC 8'hC8
`define SAR_STEP_CYC 4'h8
`define TRIM_START 4'h8

`endif

// *** rtl/adc_seq_pkg.sv ***
// Types shared by the conversion sequencer modules.
package adc_seq_pkg;
  typedef enum logic [1:0] {ST_CAL, ST_IDLE, ST_CONV} seq_state_t;
  typedef enum logic {SAR_IDLE, SAR_RUN} sar_state_t;
  typedef logic [15:0] result_t;
endpackage

// *** rtl/pin_sync.sv ***
// Two-flop synchroniser for pins from outside the pclk domain.
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 3
) (
  input wire logic pclk, // Master clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic [W-1:0] din, // Raw pin levels.
  output logic [W-1:0] dout // Synchronised levels.
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;
endmodule // pin_sync

// *** rtl/sar_engine.sv ***
// Successive-approximation search over the 16-bit capacitor array code.
`timescale 1ns/10ps
`include "adc_seq_regs.svh"
module sar_engine (
  input wire logic pclk, // Master clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic start, // One-cycle pulse to begin a conversion.
  input wire logic cmp_in, // High while held input is at or above the trial.
  input wire logic sat_hi, // Held input above the positive reference.
  input wire logic sat_lo, // Held input below the negative reference.
  output adc_seq_pkg::result_t trial_code, // Trial code to the array.
  output logic [3:0] bit_idx, // Bit under decision.
  output logic busy, // Search in progress.
  output logic done, // One-cycle pulse, result valid.
  output logic saturated // One-cycle pulse with done when clipped.
);
  import adc_seq_pkg::*;

  sar_state_t st_q, st_d;
  result_t code_q, code_d;
  logic [3:0] bit_q, bit_d;
  logic [3:0] step_q, step_d;
  logic done_q, done_d;
  logic sat_q, sat_d;

  always_comb begin
    st_d = st_q;
    code_d = code_q;
    bit_d = bit_q;
    step_d = step_q;
    done_d = 1'b0;
    sat_d = 1'b0;
    case (st_q)
      SAR_IDLE: begin
        if (start) begin
          if (sat_hi) begin
            code_d = 16'hFFFF;
            done_d = 1'b1;
            sat_d = 1'b1;
          end else if (sat_lo) begin
            code_d = 16'h0000;
            done_d = 1'b1;
            sat_d = 1'b1;
          end else begin
            code_d = 16'h8000;
            bit_d = 4'hF;
            step_d = 4'h0;
            st_d = SAR_RUN;
          end
        end
      end
      SAR_RUN: begin
        // The step length gives the comparator time to settle before each decision.
        if (step_q == `SAR_STEP_CYC - 4'h1) begin
          step_d = 4'h0;
          if (!cmp_in) begin
            code_d[bit_q] = 1'b0;
          end
          if (bit_q == 4'h0) begin
            done_d = 1'b1;
            st_d = SAR_IDLE;
          end else begin
            bit_d = bit_q - 4'h1;
            code_d[bit_q - 4'h1] = 1'b1;
          end
        end else begin
          step_d = step_q + 4'h1;
        end
      end
      default: st_d = SAR_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= SAR_IDLE;
      code_q <= 16'h0000;
      bit_q <= 4'h0;
      step_q <= 4'h0;
      done_q <= 1'b0;
      sat_q <= 1'b0;
    end else begin
      st_q <= st_d;
      code_q <= code_d;
      bit_q <= bit_d;
      step_q <= step_d;
      done_q <= done_d;
      sat_q <= sat_d;
    end
  end

  assign trial_code = code_q;
  assign bit_idx = bit_q;
  assign busy = (st_q == SAR_RUN);
  assign done = done_q;
  assign saturated = sat_q;

  sat_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    (start && !busy && sat_hi) |=> (done && trial_code == 16'hFFFF))
    else $error("saturation high did not give all ones");
  sat_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (start && !busy && !sat_hi && sat_lo) |=> (done && trial_code == 16'h0000))
    else $error("saturation low did not give all zeros");
  bit_decide_a: assert property (@(posedge pclk) disable iff (!presetn)
    (busy && step_q == 4'h7 && !cmp_in) |=> !trial_code[$past(bit_q)])
    else $error("rejected trial bit was kept");
  conv_length_a: assert property (@(posedge pclk) disable iff (!presetn)
    (start && !busy && !sat_hi && !sat_lo) |-> ##129 done)
    else $error("search did not finish in sixteen steps");
endmodule // sar_engine

// *** rtl/adc_conv_seq.sv ***
// Conversion sequencer: calibration, hold timing, serial output and APB registers.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "adc_seq_regs.svh"
module adc_conv_seq #(
  parameter int CAL_CYC = `CAL_CYC_DEFAULT
) (
  input wire logic pclk, // Master clock, 200 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  output logic irq, // Level interrupt.
  input wire logic hold_n_pin, // Hold strobe, active low, from the host.
  input wire logic chan_sel_pin, // Channel select, high for left.
  input wire logic sclk_pin, // Serial bit clock from the receiver.
  input wire logic cmp_in, // Comparator, high when input at or above trial.
  input wire logic over_hi, // Held input above the positive reference.
  input wire logic under_lo, // Held input below the negative reference.
  input wire logic cal_cmp, // Calibration comparator, high when weight too small.
  output logic calib_done_ready, // High once calibration has finished.
  output logic track_left_out, // Left track control.
  output logic track_right_out, // Right track control.
  output logic ext_sample_ctrl_a, // External sample-hold control A.
  output logic ext_sample_ctrl_b, // External sample-hold control B.
  output logic serial_result_out, // Serial result data.
  output logic input_track, // High while the array tracks the input.
  output logic acq_left, // Channel being acquired, high for left.
  output adc_seq_pkg::result_t dac_code, // Trial code to the array.
  output logic [3:0] trim_sel, // Bit whose trim is applied.
  output logic [3:0] trim_val // Trim coefficient for that bit.
);
  import adc_seq_pkg::*;

  logic hold_s, lr_s, sclk_s;
  logic sar_busy, sar_done, sar_sat;
  logic [3:0] sar_bit;
  logic hold_fall, hold_rise, sclk_fall, hold_go;

  seq_state_t st_q, st_d;
  logic [`CAL_CNT_W-1:0] cal_cnt_q, cal_cnt_d;
  logic [3:0] stp_q, stp_d, cbit_q, cbit_d, trial_q, trial_d;
  logic [1:0] tbit_q, tbit_d;
  logic trimming_q, trimming_d, ready_q, ready_d;
  logic trk_q, trk_d, sha_q, sha_d, shb_q, shb_d;
  logic [7:0] hcnt_q, hcnt_d;
  logic inp_q, inp_d, acq_q, acq_d, hprev_q, hprev_d, sprev_q, sprev_d;
  result_t res_q, res_d, shf_q, shf_d, fmt_res;
  logic [3:0] tsel_q, tsel_d, tval_q, tval_d;
  logic coef_we;
  logic [3:0] coef_val;
  logic [`TRIM_W-1:0] coef_q [16];
  logic ctrl_twos_q;

  pin_sync #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({hold_n_pin, chan_sel_pin, sclk_pin}),
    .dout({hold_s, lr_s, sclk_s})
  );

  sar_engine u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .start(hold_go),
    .cmp_in(cmp_in),
    .sat_hi(over_hi),
    .sat_lo(under_lo),
    .trial_code(dac_code),
    .bit_idx(sar_bit),
    .busy(sar_busy),
    .done(sar_done),
    .saturated(sar_sat)
  );

  assign hold_fall = hprev_q & ~hold_s;
  assign hold_rise = ~hprev_q & hold_s;
  assign sclk_fall = sprev_q & ~sclk_s;
  // Strobes before ready or during a conversion are ignored.
  assign hold_go = hold_fall && (st_q == ST_IDLE);
  assign fmt_res = ctrl_twos_q ? {~res_q[15], res_q[14:0]} : res_q;

  always_comb begin
    st_d = st_q;
    cal_cnt_d = cal_cnt_q;
    stp_d = stp_q;
    cbit_d = cbit_q;
    tbit_d = tbit_q;
    trial_d = trial_q;
    trimming_d = trimming_q;
    ready_d = ready_q;
    trk_d = trk_q;
    sha_d = sha_q;
    shb_d = shb_q;
    hcnt_d = hcnt_q;
    inp_d = inp_q;
    acq_d = acq_q;
    res_d = res_q;
    shf_d = shf_q;
    hprev_d = hold_s;
    sprev_d = sclk_s;
    coef_we = 1'b0;
    coef_val = trial_q;
    case (st_q)
      ST_CAL: begin
        cal_cnt_d = cal_cnt_q + `CAL_CNT_W'(1);
        if (trimming_q) begin
          if (stp_q == `SAR_STEP_CYC - 4'h1) begin
            stp_d = 4'h0;
            if (!cal_cmp) begin
              trial_d[tbit_q] = 1'b0;
            end
            if (tbit_q == 2'h0) begin
              coef_we = 1'b1;
              coef_val = trial_d;
              trial_d = `TRIM_START;
              tbit_d = 2'h3;
              if (cbit_q == 4'h1) begin
                trimming_d = 1'b0;
              end else begin
                cbit_d = cbit_q - 4'h1;
              end
            end else begin
              tbit_d = tbit_q - 2'h1;
              trial_d[tbit_q - 2'h1] = 1'b1;
            end
          end else begin
            stp_d = stp_q + 4'h1;
          end
        end
        if (cal_cnt_q == `CAL_CNT_W'(CAL_CYC - 1)) begin
          st_d = ST_IDLE;
          ready_d = 1'b1;
        end
      end
      ST_IDLE: begin
        if (hold_go) begin
          st_d = ST_CONV;
          inp_d = 1'b0;
        end
      end
      ST_CONV: begin
        if (sar_done) begin
          st_d = ST_IDLE;
          inp_d = 1'b1;
          acq_d = lr_s;
          res_d = dac_code;
        end
      end
      default: st_d = ST_CAL;
    endcase
    // Track fall is timed from the strobe fall; a strobe rise cancels it only when it lands in the fall cycle.
    if (hcnt_q == `TRK_FALL_CYC) begin
      trk_d = 1'b0;
      sha_d = 1'b0;
      hcnt_d = 8'h00;
    end else if (hcnt_q != 8'h00) begin
      hcnt_d = hcnt_q + 8'h01;
    end
    if (hold_go) begin
      shb_d = 1'b0;
      hcnt_d = 8'h01;
      shf_d = fmt_res;
    end else if (sclk_fall) begin
      shf_d = {shf_q[14:0], 1'b0};
    end
    if (hold_rise) begin
      trk_d = 1'b1;
      sha_d = 1'b1;
      shb_d = 1'b1;
    end
    tsel_d = trimming_q ? cbit_q : sar_bit;
    tval_d = trimming_q ? trial_q : coef_q[sar_bit];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_CAL;
      cal_cnt_q <= '0;
      stp_q <= 4'h0;
      cbit_q <= 4'hF;
      tbit_q <= 2'h3;
      trial_q <= `TRIM_START;
      trimming_q <= 1'b1;
      ready_q <= 1'b0;
      trk_q <= 1'b1;
      sha_q <= 1'b1;
      shb_q <= 1'b1;
      hcnt_q <= 8'h00;
      inp_q <= 1'b1;
      acq_q <= 1'b0;
      res_q <= 16'h0000;
      shf_q <= 16'h0000;
      hprev_q <= 1'b0;
      sprev_q <= 1'b0;
      tsel_q <= 4'h0;
      tval_q <= 4'h0;
    end else begin
      st_q <= st_d;
      cal_cnt_q <= cal_cnt_d;
      stp_q <= stp_d;
      cbit_q <= cbit_d;
      tbit_q <= tbit_d;
      trial_q <= trial_d;
      trimming_q <= trimming_d;
      ready_q <= ready_d;
      trk_q <= trk_d;
      sha_q <= sha_d;
      shb_q <= shb_d;
      hcnt_q <= hcnt_d;
      inp_q <= inp_d;
      acq_q <= acq_d;
      res_q <= res_d;
      shf_q <= shf_d;
      hprev_q <= hprev_d;
      sprev_q <= sprev_d;
      tsel_q <= tsel_d;
      tval_q <= tval_d;
    end
  end

  // Coefficients stay valid across conversions until the next reset.
  for (genvar i = 0; i < 16; i++) begin : g_coef
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        coef_q[i] <= 4'h0;
      end else if (coef_we && cbit_q == 4'(i)) begin
        coef_q[i] <= coef_val;
      end
    end
  end

  assign calib_done_ready = ready_q;
  assign track_left_out = trk_q;
  assign track_right_out = trk_q;
  assign ext_sample_ctrl_a = sha_q;
  assign ext_sample_ctrl_b = shb_q;
  assign serial_result_out = shf_q[15];
  assign input_track = inp_q;
  assign acq_left = acq_q;
  assign trim_sel = tsel_q;
  assign trim_val = tval_q;

  // APB slave: zero wait states, read data captured in the setup cycle.
  logic ctrl_twos_d;
  logic [`IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d, ievt;
  logic [31:0] prdata_q, prdata_d;
  logic wr_en, mapped;

  assign wr_en = psel & penable & pwrite;
  assign mapped = (paddr == `REG_CTRL) || (paddr == `REG_STATUS) ||
                  (paddr == `REG_IRQ_STAT) || (paddr == `REG_IRQ_MASK) ||
                  (paddr == `REG_RESULT);
  assign ievt = {sar_sat, ready_d & ~ready_q, sar_done};

  always_comb begin
    ctrl_twos_d = ctrl_twos_q;
    imask_d = imask_q;
    ist_d = ist_q;
    prdata_d = prdata_q;
    if (wr_en && paddr == `REG_CTRL) begin
      ctrl_twos_d = pwdata[`CTRL_TWOS_BIT];
    end
    if (wr_en && paddr == `REG_IRQ_MASK) begin
      imask_d = pwdata[`IRQ_W-1:0];
    end
    if (wr_en && paddr == `REG_IRQ_STAT) begin
      ist_d = ist_q & ~pwdata[`IRQ_W-1:0];
    end
    // A new event in the clearing cycle survives the clear.
    ist_d = ist_d | ievt;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `REG_CTRL: prdata_d = {31'h0, ctrl_twos_q};
        `REG_STATUS: prdata_d = {29'h0, acq_q, st_q == ST_CONV, ready_q};
        `REG_IRQ_STAT: prdata_d = {29'h0, ist_q};
        `REG_IRQ_MASK: prdata_d = {29'h0, imask_q};
        `REG_RESULT: prdata_d = {16'h0, res_q};
        default: prdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_twos_q <= `CTRL_RESET;
      imask_q <= `IRQ_MASK_RESET;
      ist_q <= '0;
      prdata_q <= 32'h0;
    end else begin
      ctrl_twos_q <= ctrl_twos_d;
      imask_q <= imask_d;
      ist_q <= ist_d;
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign irq = |(ist_q & imask_q);

  // Helper count of cycles from reset release until ready goes high, read only by checks.
  logic [`CAL_CNT_W-1:0] since_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_q <= '0;
    end else if (!ready_q) begin
      since_q <= since_q + `CAL_CNT_W'(1);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_low_a: assert property ((st_q == ST_CAL) |-> !calib_done_ready)
    else $error("ready high during calibration");
  cal_length_a: assert property ($rose(calib_done_ready) |->
    since_q == `CAL_CNT_W'(CAL_CYC))
    else $error("calibration length wrong");
  track_fall_a: assert property ((hcnt_q == `TRK_FALL_CYC && !hold_rise) |=>
    (!track_left_out && !track_right_out && !ext_sample_ctrl_a))
    else $error("track outputs did not fall");
  track_early_a: assert property ($fell(track_left_out) |->
    $past(hcnt_q) == `TRK_FALL_CYC)
    else $error("track outputs fell early");
  hold_rise_a: assert property (hold_rise |=>
    (track_left_out && ext_sample_ctrl_a && ext_sample_ctrl_b))
    else $error("controls not high after strobe rise");
  first_bit_a: assert property (hold_go |=> serial_result_out == $past(fmt_res[15]))
    else $error("first serial bit not driven at strobe fall");
  serial_edge_a: assert property ($changed(serial_result_out) |->
    $past(sclk_fall || hold_go))
    else $error("serial data changed without a bit clock fall");
  hold_input_a: assert property ((st_q == ST_CONV) |-> !input_track)
    else $error("input tracked during conversion");
  retrack_a: assert property ($rose(input_track) |-> $past(sar_done) &&
    acq_left == $past(lr_s))
    else $error("tracking resumed without conversion end");

  cal_done_c: cover property ($rose(calib_done_ready));
  conv_done_c: cover property ((st_q == ST_CONV) ##1 $rose(input_track));
  shift_c: cover property (hold_go ##[1:300] sclk_fall);
endmodule // adc_conv_seq

// *** sim/host_model.sv ***
// Host timing generator, serial receiver and analog front end facing the sequencer.
`timescale 1ns/10ps
module host_model (
  input wire logic pclk, // Master clock.
  input wire logic input_track, // Array follows the input.
  input wire logic serial_result_out, // Serial result data.
  input wire adc_seq_pkg::result_t dac_code, // Trial code on the array.
  input wire logic [3:0] trim_sel, // Bit whose trim is applied.
  input wire logic [3:0] trim_val, // Trim the sequencer applies to that bit.
  output logic hold_n_pin, // Hold strobe, active low.
  output logic chan_sel_pin, // Channel select.
  output logic sclk_pin, // Serial bit clock.
  output logic cmp_in, // Comparator.
  output logic over_hi, // Above the positive reference.
  output logic under_lo, // Below the negative reference.
  output logic cal_cmp // Calibration comparator.
);
  import adc_seq_pkg::*;
  result_t vin = 16'h0000;
  result_t held = 16'h0000;
  logic [1:0] rng = 2'h0;
  logic [1:0] held_rng = 2'h0;
  result_t rx_word = 16'h0000;
  int unstable = 0;
  initial begin
    hold_n_pin = 1'b1;
    chan_sel_pin = 1'b0;
    sclk_pin = 1'b0;
  end
  // Charge is trapped once tracking stops, so later input moves must not reach the search.
  always @(posedge pclk) begin
    if (input_track) begin
      held <= vin;
      held_rng <= rng;
    end
  end
  // Each bit has a fixed ideal trim, so a search that keeps a trial bit
  // while the trial is not above it must land exactly on that trim.
  assign cal_cmp = trim_val <= (trim_sel ^ 4'h5);
  assign cmp_in = held >= dac_code;
  assign over_hi = held_rng == 2'h1;
  assign under_lo = held_rng == 2'h2;
  // The bit clock stands low between frames and changes only on pclk rising edges within one.
  task automatic frame(input result_t v, input logic [1:0] r, input logic ch, input int hlen);
    @(posedge pclk);
    vin <= v;
    rng <= r;
    repeat (4) @(posedge pclk);
    hold_n_pin <= 1'b0;
    chan_sel_pin <= ch;
    fork
      begin
        repeat (hlen) @(posedge pclk);
        hold_n_pin <= 1'b1;
      end
      begin
        repeat (10) @(posedge pclk);
        vin <= ~v;
        rng <= 2'h0;
        // Twelve cycles high and thirteen low give the 125 ns bit clock.
        for (int i = 15; i >= 0; i--) begin
          @(posedge pclk);
          sclk_pin <= 1'b1;
          rx_word[i] = serial_result_out;
          repeat (12) @(posedge pclk);
          if (serial_result_out !== rx_word[i]) unstable++;
          sclk_pin <= 1'b0;
          repeat (12) @(posedge pclk);
        end
      end
    join
  endtask
endmodule // host_model

// *** sim/testbench.sv ***
// Self-checking bench for the conversion sequencer against a queue-based result model.
`timescale 1ns/10ps
module testbench;
  import adc_seq_pkg::*;
  localparam int CAL = 1000;
  localparam int LIMIT = 20000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, calib_done_ready, track_left_out, track_right_out;
  logic ext_sample_ctrl_a, ext_sample_ctrl_b, serial_result_out, input_track, acq_left;
  logic hold_n_pin, chan_sel_pin, sclk_pin, cmp_in, over_hi, under_lo, cal_cmp;
  result_t dac_code;
  logic [3:0] trim_sel, trim_val;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  logic twos = 1'b0;
  result_t exp_q[$];
  adc_conv_seq #(.CAL_CYC(CAL)) adc_conv_seq_inst (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq, .hold_n_pin, .chan_sel_pin, .sclk_pin,
    .cmp_in, .over_hi, .under_lo, .cal_cmp, .calib_done_ready, .track_left_out,
    .track_right_out, .ext_sample_ctrl_a, .ext_sample_ctrl_b, .serial_result_out,
    .input_track, .acq_left, .dac_code, .trim_sel, .trim_val);
  host_model host (.pclk, .input_track, .serial_result_out, .dac_code, .trim_sel, .trim_val,
    .hold_n_pin, .chan_sel_pin, .sclk_pin, .cmp_in, .over_hi, .under_lo, .cal_cmp);
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      give_verdict();
    end
  end
  // Edge timing of the track outputs, measured in pclk cycles from the strobe edges.
  logic hold_d = 1'b1;
  logic trk_d = 1'b1;
  int since_fall = 0;
  int since_rise = 0;
  always @(posedge pclk) begin
    hold_d <= hold_n_pin;
    trk_d <= track_left_out;
    since_fall <= (hold_d && !hold_n_pin) ? 1 : since_fall + 1;
    since_rise <= (!hold_d && hold_n_pin) ? 1 : since_rise + 1;
    if (presetn && trk_d && !track_left_out) begin
      chk(32'(since_fall >= 198 && since_fall <= 214), 1);
      chk(32'({track_right_out, ext_sample_ctrl_a}), 0);
    end
    if (presetn && calib_done_ready && !trk_d && track_left_out) begin
      chk(32'(since_rise <= 8), 1);
      chk(32'({track_right_out, ext_sample_ctrl_a, ext_sample_ctrl_b}), 7);
    end
  end
  // Stored trims must reach the array while converting; bit 0 is never trimmed.
  always @(negedge pclk) begin
    if (presetn && calib_done_ready && !input_track) begin
      chk(32'(trim_val), 32'((trim_sel == 4'h0) ? 4'h0 : (trim_sel ^ 4'h5)));
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] ex, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, ex);
    chk(32'(e), 32'(ee));
  endtask
  task automatic chk_irq(input logic e);
    #1;
    chk(32'(irq), 32'(e));
  endtask
  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    #1;
    chk(32'({calib_done_ready, track_left_out, track_right_out, ext_sample_ctrl_a,
      ext_sample_ctrl_b, serial_result_out, irq, acq_left}), 32'h78);
    @(posedge pclk);
    presetn <= 1'b1;
    exp_q = {16'h0000};
    twos = 1'b0;
  endtask
  task automatic wait_cal;
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      #1;
    end while (calib_done_ready !== 1'b1 && n < 2 * CAL);
    chk(n, CAL);
  endtask
  task automatic post_cal;
    rchk(8'h00, 0, 1'b0);
    rchk(8'h0C, 0, 1'b0);
    rchk(8'h04, 1, 1'b0);
    rchk(8'h08, 2, 1'b0);
    chk_irq(1'b0);
    wr(8'h0C, 7);
    chk_irq(1'b1);
    wr(8'h08, 2);
    chk_irq(1'b0);
  endtask
  task automatic run_frame(input result_t v, input logic [1:0] r, input logic ch);
    result_t res;
    result_t ex;
    res = (r == 2'h1) ? 16'hFFFF : (r == 2'h2) ? 16'h0000 : v;
    ex = exp_q.pop_front();
    host.frame(v, r, ch, 100);
    chk(32'(host.rx_word), 32'({ex[15] ^ twos, ex[14:0]}));
    exp_q.push_back(res);
    rchk(8'h10, 32'(res), 1'b0);
    rchk(8'h08, (r != 2'h0) ? 5 : 1, 1'b0);
    chk_irq(1'b1);
    wr(8'h08, 7);
    chk_irq(1'b0);
    chk(32'(acq_left), 32'(ch));
    chk(32'(host.unstable), 0);
  endtask
  initial begin
    int seed;
    seed = $urandom(1412);
    do_reset();
    repeat (300) @(posedge pclk);
    do_reset();
    wait_cal();
    post_cal();
    rchk(8'h20, 0, 1'b1);
    wr(8'h04, 32'hFFFFFFFF);
    rchk(8'h04, 1, 1'b0);
    for (int k = 0; k < 8; k++) begin
      if (k == 4) begin
        twos = 1'b1;
        wr(8'h00, 1);
      end
      run_frame((k == 6) ? 16'hFFFF : 16'($urandom), (k == 2) ? 2'h1 : (k == 5) ? 2'h2 : 2'h0,
        k[0]);
    end
    // A reset in mid-conversion must abort it and recalibrate from scratch.
    fork
      host.frame(16'h1234, 2'h0, 1'b0, 100);
    join_none
    repeat (60) @(posedge pclk);
    do_reset();
    wait_cal();
    wait fork;
    host.unstable = 0;
    post_cal();
    run_frame(16'h8001, 2'h0, 1'b1);
    give_verdict();
  end
endmodule // testbench
